// ==== common/pmp_pkg.sv ====
// Shared constants and types of the pattern memory playback block
`default_nettype none
package pmp_pkg;
	// Word field positions
	localparam int PMP_BIT_DATA = 0;
	localparam int PMP_BIT_BURST = 2;
	localparam int PMP_BIT_EVENT1 = 6;
	localparam int PMP_BIT_END = 7;
	// Memory geometry: 8 Mbyte array, base build limited to 1 Mbyte
	localparam int PMP_ADDR_W = 23;
	localparam int PMP_CNT_W = 24;
	localparam int PMP_MEM_DEPTH = 8388608;
	localparam logic [23:0] PMP_CAP_BASE = 24'h100000;
	localparam logic [23:0] PMP_CAP_EXT = 24'h800000;
	// Error code for a download that does not fit
	localparam logic signed [15:0] PMP_ERR_TOO_MUCH = -16'sd223;
	localparam logic signed [15:0] PMP_ERR_NONE = 16'sh0000;
	// Typical list values
	localparam logic [7:0] PMP_WORD_ONE = 8'h15;
	localparam logic [7:0] PMP_WORD_ZERO = 8'h14;
	localparam logic [7:0] PMP_WORD_OFF = 8'h10;
	localparam logic [7:0] PMP_WORD_OFF_END = 8'h90;
	// Download FIFO shape
	localparam int PMP_FIFO_W = 8;
	localparam int PMP_FIFO_DEPTH = 32;
	// Generated pattern written on format activation
	localparam logic [4:0] PMP_GEN_LAST = 5'h1f;
	localparam logic [7:0] PMP_LFSR_SEED = 8'h01;
	// Reset values
	localparam logic [22:0] PMP_ADDR_START = 23'h000000;
	localparam logic [23:0] PMP_CNT_START = 24'h000000;
	typedef struct packed {
		logic end_bit;
		logic event1;
		logic rsv5;
		logic rsv4;
		logic rsv3;
		logic burst;
		logic rsv1;
		logic data;
	} pmp_word_type;
	typedef enum logic [0:0] {
		PMP_ST_RUN = 1'b0,
		PMP_ST_FILL = 1'b1
	} pmp_state_type;
	// Modulation bit actually sent: data is ignored while burst is off
	function automatic logic pmp_play_bit(input pmp_word_type w);
		pmp_play_bit = w.burst & w.data;
	endfunction
endpackage
`default_nettype wire

// ==== dv/pmp_host_model.sv ====
// Host model that downloads a list of pattern words
`timescale 1ns/1ps
`default_nettype none
module pmp_host_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic [6:0] n,
	input wire logic slow,
	input wire logic [7:0] words [64],
	input wire logic dl_ready,
	output logic dl_start,
	output logic dl_valid,
	output logic [7:0] dl_data,
	output logic done
);
	int k;
	initial begin
		dl_start = 1'b0;
		dl_valid = 1'b0;
		dl_data = 8'h00;
		done = 1'b1;
		forever begin
			@(posedge mclk);
			if (go) begin
				done <= 1'b0;
				dl_start <= 1'b1;
				@(posedge mclk);
				dl_start <= 1'b0;
				for (k = 0; k < n; k++) begin
					dl_valid <= 1'b1;
					dl_data <= words[k];
					do @(posedge mclk); while (!dl_ready);
					if (slow) begin
						dl_valid <= 1'b0;
						dl_data <= ~words[k];
						@(posedge mclk);
					end
				end
				dl_valid <= 1'b0;
				if (!slow) dl_data <= ~dl_data;
				done <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/pmp_playback_tb.sv ====
// Testbench of the pattern memory playback block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module pmp_playback_tb import pmp_pkg::*;;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic play_enable = 1'b0;
	logic data_tick = 1'b0;
	logic format_activate = 1'b0;
	logic ext_config = 1'b0;
	logic [6:0] n = 7'h00;
	logic [7:0] host_words [64];
	logic dl_start, dl_valid, dl_ready, mod_data, rf_enable, event1;
	logic pattern_present, too_much_data, fill_busy, host_done;
	logic [7:0] dl_data;
	logic signed [15:0] error_code;
	logic [22:0] play_addr;
	logic ev = 1'b0;
	int num_errors = 0;
	int total_checks = 0;
	pmp_host_model i_pmp_host_model (.mclk(mclk), .go(go), .n(n), .slow(slow),
		.words(host_words), .dl_ready(dl_ready), .dl_start(dl_start),
		.dl_valid(dl_valid), .dl_data(dl_data), .done(host_done));
	pmp_playback i_pmp_playback (.mclk(mclk), .reset(reset), .dl_start(dl_start),
		.dl_valid(dl_valid), .dl_data(dl_data), .dl_ready(dl_ready), .ext_config(ext_config),
		.play_enable(play_enable), .data_tick(data_tick), .format_activate(format_activate),
		.mod_data(mod_data), .rf_enable(rf_enable), .event1(event1),
		.pattern_present(pattern_present), .too_much_data(too_much_data),
		.error_code(error_code), .play_addr(play_addr), .fill_busy(fill_busy));
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic load(input int cnt, input logic s);
		int i;
		for (i = 0; i < cnt; i++) begin
			host_words[i] = (i == cnt - 1) ? 8'h90 : (i == 0) ? 8'h55 : (i < 20) ?
				((i % 4 < 2) ? 8'h15 : 8'h14) : ((i % 2) ? 8'h11 : 8'h10);
		end
		@(posedge mclk);
		n <= cnt[6:0];
		slow <= s;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
	endtask
	task automatic wait_present();
		int k;
		for (k = 0; k < 400 && (host_done !== 1'b1 || pattern_present !== 1'b1); k++) begin
			@(negedge mclk);
		end
		if (k == 400) begin
			num_errors++;
			end_of_test();
		end
	endtask
	task automatic t_reset();
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		`CHK({dl_ready, mod_data, rf_enable, event1, fill_busy}, 5'h10)
		`CHK({pattern_present, too_much_data, play_addr}, 25'h0)
	endtask
	task automatic t_fill_dl();
		int busy;
		int full;
		busy = 0;
		full = 0;
		load(40, 1'b0);
		@(posedge mclk);
		format_activate <= 1'b1;
		@(posedge mclk);
		format_activate <= 1'b0;
		repeat (120) begin
			@(negedge mclk);
			busy += (fill_busy === 1'b1);
			full += !dl_ready;
		end
		`CHK(busy, 32)
		`CHK(full > 0, 1'b1)
		wait_present();
		`CHK(too_much_data, 1'b0)
		`CHK(error_code, 16'sh0000)
	endtask
	task automatic play(input int ticks);
		int a;
		int t;
		logic [7:0] w;
		a = 0;
		@(posedge mclk);
		play_enable <= 1'b1;
		data_tick <= 1'b1;
		for (t = 0; t < ticks; t++) begin
			@(posedge mclk);
			if (t == ticks - 1) data_tick <= 1'b0;
			@(negedge mclk);
			w = host_words[a];
			ev ^= w[6];
			a = w[7] ? 0 : a + 1;
			`CHK(mod_data, w[0] & w[2])
			`CHK(rf_enable, w[2])
			`CHK(event1, ev)
			`CHK(play_addr, a[22:0])
		end
	endtask
	task automatic t_mute();
		@(posedge mclk);
		play_enable <= 1'b0;
		data_tick <= 1'b1;
		repeat (3) @(posedge mclk);
		data_tick <= 1'b0;
		@(negedge mclk);
		`CHK({play_addr, rf_enable, mod_data}, 25'h0)
	endtask
	task automatic t_small();
		load(0, 1'b0);
		repeat (4) @(negedge mclk);
		`CHK(pattern_present, 1'b0)
		@(posedge mclk);
		ext_config <= 1'b1;
		load(4, 1'b1);
		wait_present();
		`CHK(pattern_present, 1'b1)
		play(6);
	endtask
	task automatic t_gen();
		int t;
		int a;
		a = 0;
		@(posedge mclk);
		format_activate <= 1'b1;
		@(posedge mclk);
		format_activate <= 1'b0;
		repeat (34) @(negedge mclk);
		`CHK({pattern_present, fill_busy, play_addr}, 25'h0)
		@(posedge mclk);
		data_tick <= 1'b1;
		for (t = 0; t <= 32; t++) begin
			@(posedge mclk);
			if (t == 32) data_tick <= 1'b0;
			@(negedge mclk);
			ev ^= (a == 0);
			a = (a == PMP_GEN_LAST) ? 0 : a + 1;
			`CHK({rf_enable, event1, play_addr}, {1'b1, ev, a[22:0]})
		end
	endtask
	initial begin
		t_reset();
		t_fill_dl();
		play(42);
		t_mute();
		t_small();
		t_gen();
		end_of_test();
	end
endmodule
`default_nettype wire

// ==== rtl/pmp_fifo.sv ====
// Download FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pmp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_valid = (count != '0);
	assign out_data = store[rptr];
	assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push)
				wptr <= wptr + 1'b1;
			if (pop)
				rptr <= rptr + 1'b1;
			count <= next_count;
			in_ready <= (next_count != DEPTH[AW:0]);
		end
	end
	always_ff @(posedge mclk) begin
		if (push)
			store[wptr] <= in_data;
	end
endmodule
`default_nettype wire

// ==== rtl/pmp_playback.sv ====
// Pattern memory with list download and word-per-period playback
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Bit 0 of each word is data
// - Data ignored while burst bit is zero
// - RF output follows played burst bit
// - Bit 6 toggles event one output
// - End bit zero advances address
// - End bit one restarts the pattern
// - Capacity 1 Mbyte base, 8 extended
// - Each list value stored consecutively
// - List values parsed before writing memory
// - One word consumed per data period
// - Values 21,20,16,144 decode as listed
// - Format activation overwrites with generated data
// - Report whether user pattern is present
// - Oversize download rejected with code -223
module pmp_playback import pmp_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic dl_start,
	input wire logic dl_valid,
	input wire logic [7:0] dl_data,
	output logic dl_ready,
	input wire logic ext_config,
	input wire logic play_enable,
	input wire logic data_tick,
	input wire logic format_activate,
	output logic mod_data,
	output logic rf_enable,
	output logic event1,
	output logic pattern_present,
	output logic too_much_data,
	output logic signed [15:0] error_code,
	output logic [22:0] play_addr,
	output logic fill_busy
);
	pmp_state_type state;
	pmp_state_type next_state;
	pmp_word_type mem [0:PMP_MEM_DEPTH-1];
	logic fifo_ready;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic fifo_take;
	logic parse_valid;
	pmp_word_type parse_word;
	logic [23:0] wr_count;
	logic [23:0] capacity;
	logic is_run;
	logic user_wr;
	logic overflow;
	logic fill_wr;
	logic mem_we;
	logic [22:0] mem_waddr;
	pmp_word_type mem_wdata;
	pmp_word_type gen_word;
	logic [4:0] fill_idx;
	logic [7:0] lfsr;
	pmp_word_type play_word;
	logic take;
	logic fill_go;
	logic fill_done;

	pmp_fifo #(
		.WIDTH(PMP_FIFO_W),
		.DEPTH(PMP_FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.reset(reset),
		.in_valid(dl_valid),
		.in_data(dl_data),
		.in_ready(dl_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(fifo_ready)
	);

	// Download path control
	assign is_run = (state == PMP_ST_RUN);
	assign fifo_ready = is_run;
	assign fifo_take = fifo_valid & fifo_ready;
	assign capacity = ext_config ? PMP_CAP_EXT : PMP_CAP_BASE;
	assign user_wr = parse_valid & is_run & ~dl_start & ~fill_go & (wr_count < capacity);
	assign overflow = parse_valid & is_run & ~dl_start & ~fill_go & (wr_count >= capacity);

	// Generated pattern for format activation
	assign fill_go = format_activate & is_run;
	assign fill_wr = ~is_run;
	assign fill_done = fill_wr & (fill_idx == PMP_GEN_LAST);
	assign gen_word = '{end_bit: fill_idx == PMP_GEN_LAST, event1: fill_idx == 5'h00,
		rsv5: 1'b0, rsv4: 1'b1, rsv3: 1'b0, burst: 1'b1, rsv1: 1'b0, data: lfsr[0]};

	// Single write port, fill has the port to itself
	assign mem_we = user_wr | fill_wr;
	assign mem_waddr = fill_wr ? {18'h00000, fill_idx} : wr_count[22:0];
	assign mem_wdata = fill_wr ? gen_word : parse_word;

	// Playback decode
	assign play_word = mem[play_addr];
	assign take = data_tick & play_enable & is_run;

	always_comb begin
		next_state = state;
		case (state)
			PMP_ST_RUN: begin
				if (fill_go)
					next_state = PMP_ST_FILL;
			end
			PMP_ST_FILL: begin
				if (fill_done)
					next_state = PMP_ST_RUN;
			end
			default: next_state = PMP_ST_RUN;
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state <= PMP_ST_RUN;
			fill_busy <= 1'b0;
			fill_idx <= 5'h00;
			lfsr <= PMP_LFSR_SEED;
		end else begin
			state <= next_state;
			fill_busy <= (next_state == PMP_ST_FILL);
			fill_idx <= fill_wr ? fill_idx + 5'h01 : 5'h00;
			if (fill_wr)
				lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		end
	end

	// Parse stage: byte split into its fields before the write
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			parse_valid <= 1'b0;
			parse_word <= '0;
		end else begin
			parse_valid <= fifo_take;
			if (fifo_take)
				parse_word <= pmp_word_type'(fifo_data);
		end
	end

	always_ff @(posedge mclk) begin
		if (mem_we)
			mem[mem_waddr] <= mem_wdata;
	end

	// Write pointer, presence and error flags
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wr_count <= PMP_CNT_START;
			pattern_present <= 1'b0;
			too_much_data <= 1'b0;
			error_code <= PMP_ERR_NONE;
		end else begin
			if (dl_start | fill_go)
				wr_count <= PMP_CNT_START;
			else if (user_wr)
				wr_count <= wr_count + 24'h000001;
			if (user_wr)
				pattern_present <= 1'b1;
			else if (dl_start | fill_wr)
				pattern_present <= 1'b0;
			if (overflow) begin
				too_much_data <= 1'b1;
				error_code <= PMP_ERR_TOO_MUCH;
			end else if (dl_start) begin
				too_much_data <= 1'b0;
				error_code <= PMP_ERR_NONE;
			end
		end
	end

	// Playback: one word per data period
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			play_addr <= PMP_ADDR_START;
			mod_data <= 1'b0;
			rf_enable <= 1'b0;
			event1 <= 1'b0;
		end else if (~is_run | fill_go | ~play_enable) begin
			play_addr <= PMP_ADDR_START;
			mod_data <= 1'b0;
			rf_enable <= 1'b0;
		end else if (take) begin
			mod_data <= pmp_play_bit(play_word);
			rf_enable <= play_word.burst;
			if (play_word.event1)
				event1 <= ~event1;
			if (play_word.end_bit)
				play_addr <= PMP_ADDR_START;
			else
				play_addr <= play_addr + 23'h000001;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence fill_seq;
		fill_busy ##31 fill_busy ##1 !fill_busy;
	endsequence

	sequence off_played;
		!rf_enable && !mod_data;
	endsequence

	data_bit_a: assert property (take && !fifo_take && play_word.burst && !fill_go |=>
		mod_data == $past(play_word.data)) else $error("data bit not played");
	burst_mute_a: assert property (take && !fill_go && !play_word.burst |=>
		!mod_data) else $error("data leaked while burst off");
	rf_gate_a: assert property (take && !fill_go |=>
		rf_enable == $past(play_word.burst)) else $error("rf enable wrong");
	event_toggle_a: assert property (take && !fill_go |=>
		(event1 ^ $past(event1)) == $past(play_word.event1)) else $error("event one wrong");
	addr_step_a: assert property (take && !fill_go && !play_word.end_bit |=>
		play_addr == $past(play_addr) + 23'h000001) else $error("address did not advance");
	pattern_wrap_a: assert property (take && !fill_go && play_word.end_bit |=>
		play_addr == PMP_ADDR_START) else $error("pattern did not restart");
	period_hold_a: assert property (is_run && play_enable && !data_tick && !fill_go |=>
		$stable(play_addr)) else $error("address moved without a data period");
	value_decode_a: assert property (take && !fill_go && (play_word == PMP_WORD_OFF ||
		play_word == PMP_WORD_OFF_END) |=> off_played) else $error("off word played");
	value_one_a: assert property (take && !fill_go && play_word == PMP_WORD_ONE |=>
		mod_data && rf_enable) else $error("word 21 misread");
	value_zero_a: assert property (take && !fill_go && play_word == PMP_WORD_ZERO |=>
		!mod_data && rf_enable) else $error("word 20 misread");
	parse_stage_a: assert property (fifo_take |=> parse_valid ##0
		parse_word == $past(fifo_data)) else $error("parse stage lost a value");
	list_store_a: assert property (user_wr |=>
		wr_count == $past(wr_count) + 24'h000001) else $error("write address not advanced");
	presence_a: assert property (user_wr |=> pattern_present) else
		$error("presence not reported");
	oversize_a: assert property (overflow |=> too_much_data &&
		error_code == PMP_ERR_TOO_MUCH) else $error("oversize not rejected");
	capacity_a: assert property (!ext_config && parse_valid && is_run && !dl_start &&
		!fill_go && wr_count == PMP_CAP_BASE |-> overflow) else $error("base limit missed");
	format_fill_a: assert property (fill_go |=> fill_seq) else
		$error("generated fill length wrong");
endmodule
`default_nettype wire
